// ### hw/slot_bus_ctrl.sv
// Slot bus cycle controller: CPU, refresh, DMA and bus-master cycles
//
// How it works
// (R1) CPU cycles drive command strobes and BALE.
// (R2) Sample 16-bit selects and channel-ready.
// (R3) Zero-wait-state input ends cycle early.
// (R4) Refresh drives indication, address, memory read.
// (R5) Channel-ready stretches refresh and memory-read pulses.
// (R6) BALE high throughout refresh cycles.
// (R7) BALE forced high for DMA cycles.
// (R8) AEN asserted during DMA cycles.
// (R9) Channel-ready extends DMA cycles.
// (R10) Acknowledged master asserting MASTER gets bus.
// (R11) Card pulls channel-ready before last wait.
// (R12) Card asserts 16-bit select before last wait; the code samples it once, at the end of the address phase.
// (R13) Control register at index 16h, port EDh.
// (R14) Bit 7 ROM width, reset from strap.
// (R15) Bit 6 drive strength, reset from pin.
// (R16) Bit 5 programmed-I/O timing, resets zero.
// (R17) Bit 4 reads one, ignores writes.
// (R18) Bit 3 adds narrow-cycle command delay; the code also applies it to 16-bit I/O cycles.
// (R19) Bit 2 adds 16-bit memory command delay.
// (R20) Bit 1 selects 16-bit wait states.
// (R21) Bit 0 selects five 8-bit wait states.
`timescale 1ns/1ns
`default_nettype none
module slot_bus_ctrl #(
  parameter int SLOT_DIV = slot_bus_pkg::SLOT_CLK_DIV,
  parameter int REFRESH_AW = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Straps
  input wire logic strap_line_a,
  input wire logic rom_select_pin,
  // Configuration port access
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // CPU cycle request
  input wire logic cpu_req,
  input wire slot_bus_pkg::slot_cycle_t cpu_type,
  input wire logic cpu_sysmem,
  output logic cpu_busy,
  output logic cpu_done,
  output logic cpu_wide,
  // Refresh request
  input wire logic refresh_req,
  output logic refresh_done,
  // DMA and bus master
  input wire logic dma_active,
  input wire logic dma_ack,
  input wire logic master_n,
  output logic dma_ready,
  output logic master_granted,
  // Slot commands
  output logic ior_n,
  output logic iow_n,
  output logic memr_n,
  output logic memw_n,
  output logic smemr_n,
  output logic smemw_n,
  output logic cmd_oe,
  output logic bale,
  output logic aen,
  output logic refresh_n,
  output logic [REFRESH_AW-1:0] refresh_addr,
  output logic refresh_addr_oe,
  // Slot responses
  input wire logic mem_cs16_n,
  input wire logic io_cs16_n,
  input wire logic iochrdy,
  input wire logic ws0_n,
  // Control bits out
  output logic rom_width_select,
  output logic slot_drive_strength,
  output logic pio_timing_select
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DELAY,
    ST_CMD,
    ST_RECOVER,
    ST_REFRESH,
    ST_DMA,
    ST_MASTER
  } state_t;

  state_t state_reg;
  logic tick;
  logic [7:0] ctrl_reg;
  logic [7:0] index_reg;
  logic strap_pending_reg;
  logic [3:0] count_reg;
  logic [3:0] wait_target;
  logic delay_needed;
  slot_bus_pkg::slot_cycle_t type_reg;
  logic sysmem_reg;
  logic is_mem;
  logic wide_sample;
  logic [7:0] ctrl_view;
  logic ctrl_selected;

  tick_divider #(
    .DIV(SLOT_DIV)
  ) u_slot_tick (
    .clock(clock),
    .nrst(nrst),
    .tick(tick)
  );

  // Register view with the reserved bit forced high
  assign ctrl_view = ctrl_reg | slot_bus_pkg::CTRL_READ_ONES; // R17
  assign ctrl_selected = (index_reg == slot_bus_pkg::CTRL_INDEX);

  // Index then data, as in the shared configuration scheme
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      index_reg <= 8'h00;
    end else if (cfg_wr && cfg_addr == slot_bus_pkg::INDEX_PORT) begin
      index_reg <= cfg_wdata; // R13
    end
  end

  // Straps are caught on the first edge after reset release
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_pending_reg <= 1'b1;
    end else begin
      strap_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= slot_bus_pkg::CTRL_RESET; // R16 R18 R19 R20 R21
    end else if (strap_pending_reg) begin
      ctrl_reg[slot_bus_pkg::ROM_WIDTH_BIT] <= strap_line_a; // R14
      ctrl_reg[slot_bus_pkg::DRIVE_BIT] <= rom_select_pin; // R15
    end else if (cfg_wr && cfg_addr == slot_bus_pkg::DATA_PORT && ctrl_selected) begin
      // Bit 4 is never stored, so writes to it vanish
      // Strap bits stay writable; the straps only seed them
      ctrl_reg <= (cfg_wdata & slot_bus_pkg::CTRL_WRITE_MASK); // R13 R17
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= slot_bus_pkg::READ_NONE;
    end else if (cfg_rd && cfg_addr == slot_bus_pkg::DATA_PORT && ctrl_selected) begin
      cfg_rdata <= ctrl_view; // R13 R17
    end else if (cfg_rd && cfg_addr == slot_bus_pkg::INDEX_PORT) begin
      cfg_rdata <= index_reg;
    end else begin
      cfg_rdata <= slot_bus_pkg::READ_NONE;
    end
  end

  // Control bits reach the pads from the register itself
  assign rom_width_select = ctrl_reg[slot_bus_pkg::ROM_WIDTH_BIT]; // R14
  assign slot_drive_strength = ctrl_reg[slot_bus_pkg::DRIVE_BIT]; // R15
  assign pio_timing_select = ctrl_reg[slot_bus_pkg::PIO_TIMING_BIT]; // R16

  assign is_mem = (type_reg == slot_bus_pkg::CYC_MEM_RD) || (type_reg == slot_bus_pkg::CYC_MEM_WR);
  // Width decided by the select that matches the cycle kind
  // Taken once at the end of the address phase; a late select leaves the cycle 8-bit
  assign wide_sample = is_mem ? !mem_cs16_n : !io_cs16_n; // R2 R12

  // Command delay: 16-bit memory uses one bit, all other cycles, 16-bit I/O included, the other
  always_comb begin
    if (is_mem && cpu_wide) begin
      delay_needed = ctrl_reg[slot_bus_pkg::WIDE_DLY_BIT]; // R19
    end else begin
      delay_needed = ctrl_reg[slot_bus_pkg::NARROW_DLY_BIT]; // R18
    end
  end

  // Wait states: 16-bit zero or one, 8-bit four or five, slow PIO one more
  always_comb begin
    if (cpu_wide) begin
      wait_target = {3'b000, ctrl_reg[slot_bus_pkg::WIDE_WAIT_BIT]}; // R20
    end else begin
      wait_target = slot_bus_pkg::NARROW_WAIT_BASE + {3'b000, ctrl_reg[slot_bus_pkg::NARROW_WAIT_BIT]}; // R21
    end
    if (!is_mem && !ctrl_reg[slot_bus_pkg::PIO_TIMING_BIT]) begin
      wait_target = wait_target + slot_bus_pkg::PIO_SLOW_EXTRA; // R16
    end
  end

  // Cycle sequencer; everything advances on the slot clock enable
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      count_reg <= 4'h0;
      type_reg <= slot_bus_pkg::CYC_IO_RD;
      sysmem_reg <= 1'b0;
      cpu_wide <= 1'b0;
      cpu_busy <= 1'b0;
    end else if (tick) begin
      case (state_reg)
        ST_IDLE: begin
          count_reg <= 4'h0;
          if (dma_active) begin
            state_reg <= ST_DMA;
          end else if (refresh_req) begin
            state_reg <= ST_REFRESH;
          end else if (cpu_req) begin
            type_reg <= cpu_type;
            sysmem_reg <= cpu_sysmem;
            cpu_busy <= 1'b1;
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          cpu_wide <= wide_sample; // R2
          state_reg <= ST_DELAY;
        end
        ST_DELAY: begin
          if (delay_needed && count_reg == 4'h0) begin
            count_reg <= slot_bus_pkg::ONE; // R18 R19
          end else begin
            count_reg <= 4'h0;
            state_reg <= ST_CMD;
          end
        end
        // No timeout: a card that never returns channel-ready holds the bus
        ST_CMD: begin
          if (!ws0_n) begin
            state_reg <= ST_RECOVER; // R3
          end else if (count_reg >= wait_target) begin
            if (iochrdy) begin
              state_reg <= ST_RECOVER; // R2 R11
            end
          end else begin
            count_reg <= count_reg + slot_bus_pkg::ONE;
          end
        end
        ST_RECOVER: begin
          cpu_busy <= 1'b0;
          state_reg <= ST_IDLE;
        end
        ST_REFRESH: begin
          if (count_reg < slot_bus_pkg::REFRESH_CMD_CLKS) begin
            count_reg <= count_reg + slot_bus_pkg::ONE;
          end else if (iochrdy) begin
            count_reg <= 4'h0;
            state_reg <= ST_IDLE; // R5
          end
        end
        ST_DMA: begin
          if (dma_ack && !master_n) begin
            state_reg <= ST_MASTER; // R10
          end else if (!dma_active) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_MASTER: begin
          if (master_n || !dma_ack) begin
            state_reg <= ST_DMA;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Completion pulses, one clock each
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cpu_done <= 1'b0;
      refresh_done <= 1'b0;
    end else begin
      cpu_done <= tick && state_reg == ST_RECOVER;
      refresh_done <= tick && state_reg == ST_REFRESH && count_reg >= slot_bus_pkg::REFRESH_CMD_CLKS && iochrdy;
    end
  end

  // Refresh row address advances once per finished refresh
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      refresh_addr <= '0;
    end else if (refresh_done) begin
      refresh_addr <= refresh_addr + REFRESH_AW'(1); // R4
    end
  end

  // Slot command strobes, registered from the sequencer state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ior_n <= 1'b1;
      iow_n <= 1'b1;
      memr_n <= 1'b1;
      memw_n <= 1'b1;
      smemr_n <= 1'b1;
      smemw_n <= 1'b1;
      refresh_n <= 1'b1;
      refresh_addr_oe <= 1'b0;
    end else begin
      ior_n <= !(state_reg == ST_CMD && type_reg == slot_bus_pkg::CYC_IO_RD); // R1
      iow_n <= !(state_reg == ST_CMD && type_reg == slot_bus_pkg::CYC_IO_WR); // R1
      memr_n <= !((state_reg == ST_CMD && type_reg == slot_bus_pkg::CYC_MEM_RD) || state_reg == ST_REFRESH); // R1 R4 R5
      memw_n <= !(state_reg == ST_CMD && type_reg == slot_bus_pkg::CYC_MEM_WR); // R1
      smemr_n <= !((state_reg == ST_CMD && type_reg == slot_bus_pkg::CYC_MEM_RD && sysmem_reg) ||
                   state_reg == ST_REFRESH); // R1 R4
      smemw_n <= !(state_reg == ST_CMD && type_reg == slot_bus_pkg::CYC_MEM_WR && sysmem_reg); // R1
      refresh_n <= !(state_reg == ST_REFRESH); // R4 R5
      refresh_addr_oe <= (state_reg == ST_REFRESH); // R4
    end
  end

  // Bus ownership: DMA controllers and masters drive commands themselves
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_oe <= 1'b1;
      bale <= 1'b0;
      aen <= 1'b0;
      master_granted <= 1'b0;
    end else begin
      cmd_oe <= !(state_reg == ST_DMA || state_reg == ST_MASTER); // R7 R10
      bale <= (state_reg == ST_ADDR) || (state_reg == ST_REFRESH) || (state_reg == ST_DMA); // R1 R6 R7
      aen <= (state_reg == ST_DMA); // R8
      master_granted <= (state_reg == ST_MASTER); // R10
    end
  end

  // Channel-ready tells the DMA logic to hold its cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dma_ready <= 1'b1;
    end else begin
      dma_ready <= (state_reg != ST_DMA) || iochrdy; // R9
    end
  end

endmodule : slot_bus_ctrl
`default_nettype wire

// ### hw/slot_bus_pkg.sv
// Shared constants for the slot bus cycle controller
package slot_bus_pkg;

  // Configuration index scheme
  localparam logic [7:0] INDEX_PORT = 8'hEC;
  localparam logic [7:0] DATA_PORT = 8'hED;
  localparam logic [7:0] CTRL_INDEX = 8'h16;

  // Field positions of slot_bus_control
  localparam int ROM_WIDTH_BIT = 7;
  localparam int DRIVE_BIT = 6;
  localparam int PIO_TIMING_BIT = 5;
  localparam int RESERVED_BIT = 4;
  localparam int NARROW_DLY_BIT = 3;
  localparam int WIDE_DLY_BIT = 2;
  localparam int WIDE_WAIT_BIT = 1;
  localparam int NARROW_WAIT_BIT = 0;

  // Reset value of the plain bits; bits 7 and 6 come from straps
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Reserved bit always reads one
  localparam logic [7:0] CTRL_READ_ONES = 8'h10;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hEF;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Wait states, in slot clocks
  localparam logic [3:0] NARROW_WAIT_BASE = 4'h4;
  localparam logic [3:0] PIO_SLOW_EXTRA = 4'h1;
  localparam logic [3:0] REFRESH_CMD_CLKS = 4'h3;
  localparam logic [3:0] ONE = 4'h1;

  // Slot clock period and the divider derived from it (least time, rounded up)
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int SLOT_CLK_PERIOD_NS = 125;
  localparam int SLOT_CLK_DIV = (SLOT_CLK_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {
    CYC_IO_RD,
    CYC_IO_WR,
    CYC_MEM_RD,
    CYC_MEM_WR
  } slot_cycle_t;

endpackage : slot_bus_pkg

// ### hw/tick_divider.sv
// One-cycle enable pulse every DIV clocks
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter int DIV = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Enable out
  output logic tick
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] count_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + W'(1);
      tick <= 1'b0;
    end
  end
endmodule : tick_divider
`default_nettype wire

// ### tb/slot_card.sv
// Behavioural add-in card on the slot side
`timescale 1ns/1ns
`default_nettype none
module slot_card (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Slot commands
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic bale,
  input wire logic aen,
  // Behaviour controls
  input wire logic wide,
  input wire logic fast,
  input wire logic [3:0] stall,
  // Card responses
  output logic mem_cs16_n,
  output logic io_cs16_n,
  output logic iochrdy,
  output logic ws0_n
);
  logic cmd, act, cmd_q, act_q, on, w0, rdy;
  logic [3:0] cnt;
  assign cmd = !(ior_n && iow_n && memr_n && memw_n);
  assign act = cmd || aen;
  // Pull-ups bring released lines high
  // Select decodes from the address, so it already stands while BALE is high
  assign mem_cs16_n = !(on || (wide && bale));
  assign io_cs16_n = !(on || (wide && bale));
  assign ws0_n = !w0;
  assign iochrdy = rdy;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {cmd_q, act_q, on, w0, rdy, cnt} <= {5'h01, 4'h0};
    end else begin
      cmd_q <= cmd;
      act_q <= act;
      on <= wide && (bale || (on && !(cmd_q && !cmd)));
      w0 <= fast && cmd;
      if (act && !act_q) begin
        cnt <= stall;
        rdy <= (stall == 4'h0);
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        rdy <= (cnt <= 4'h1);
      end else begin
        rdy <= 1'b1;
      end
    end
  end
endmodule : slot_card
`default_nettype wire

// ### tb/slot_bus_ctrl_sva.sv
// Checker for the slot bus cycle controller ports
`timescale 1ns/1ns
`default_nettype none
module slot_bus_ctrl_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_rdata,
  input wire logic cpu_busy,
  input wire logic dma_active,
  input wire logic dma_ack,
  input wire logic master_n,
  input wire logic dma_ready,
  input wire logic master_granted,
  input wire logic memr_n,
  input wire logic cmd_oe,
  input wire logic bale,
  input wire logic aen,
  input wire logic refresh_n,
  input wire logic refresh_addr_oe,
  input wire logic iochrdy,
  input wire logic rom_width_select,
  input wire logic slot_drive_strength,
  input wire logic pio_timing_select
);
  logic data_read;
  // Marks the clock in which cfg_rdata answers a data port read
  always_ff @(posedge clock) begin
    data_read <= cfg_rd && (cfg_addr == slot_bus_pkg::DATA_PORT);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  AST_CPU_BALE: assert property ($rose(cpu_busy) |-> ##[0:2] bale)
    else $error("no address phase at cycle start");
  AST_REF_MEMR: assert property ($fell(refresh_n) |-> ##[0:1] !memr_n)
    else $error("refresh without memory read");
  AST_REF_STRETCH: assert property ((!refresh_n && !iochrdy) [*3] |=> !refresh_n)
    else $error("refresh ended while not ready");
  AST_REF_BALE: assert property (!refresh_n |-> bale && refresh_addr_oe)
    else $error("refresh without bale or address");
  AST_DMA_BALE: assert property (aen |-> bale && !cmd_oe)
    else $error("dma state without bale");
  AST_DMA_READY: assert property (aen |-> dma_ready == $past(iochrdy))
    else $error("dma cycle not extended");
  AST_MASTER_GRANT: assert property ((dma_active && dma_ack && !master_n) [*8] |-> master_granted)
    else $error("master not granted");
  AST_MASTER_FREE: assert property (master_granted |-> !cmd_oe && !aen)
    else $error("bus not released to master");
  AST_CFG_IDLE: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00)
    else $error("read data without read");
  AST_CFG_RSV: assert property (data_read && |cfg_rdata |-> cfg_rdata[4])
    else $error("reserved bit read zero");
  AST_CFG_FIELDS: assert property (data_read && |cfg_rdata |->
    cfg_rdata[7:5] == {rom_width_select, slot_drive_strength, pio_timing_select})
    else $error("control outputs differ from register");
endmodule : slot_bus_ctrl_sva
bind slot_bus_ctrl slot_bus_ctrl_sva chk (.clock, .nrst, .cfg_rd, .cfg_addr, .cfg_rdata, .cpu_busy, .dma_active,
  .dma_ack, .master_n, .dma_ready, .master_granted, .memr_n, .cmd_oe, .bale, .aen, .refresh_n,
  .refresh_addr_oe, .iochrdy, .rom_width_select, .slot_drive_strength, .pio_timing_select);
`default_nettype wire

// ### tb/tb.sv
// Self-checking testbench for the slot bus cycle controller
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock, nrst, strap_line_a, rom_select_pin, cfg_wr, cfg_rd, cpu_req, cpu_sysmem, refresh_req;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, refresh_addr, len, v, rnd;
  slot_bus_pkg::slot_cycle_t cpu_type;
  logic cpu_busy, cpu_done, cpu_wide, refresh_done, dma_active, dma_ack, master_n, dma_ready;
  logic master_granted, ior_n, iow_n, memr_n, memw_n, smemr_n, smemw_n, cmd_oe, bale, aen;
  logic refresh_n, refresh_addr_oe, mem_cs16_n, io_cs16_n, iochrdy, ws0_n, card_wide, card_fast, rd_q;
  logic rom_width_select, slot_drive_strength, pio_timing_select;
  logic [3:0] card_stall;
  logic [1:0] mode;
  logic [7:0] exp_q[$];
  logic [7:0] ctab[5] = '{8'h00, 8'h01, 8'h02, 8'h20, 8'h0F};
  int fails = 0, checks = 0, spin = 0;
  wire logic [1:0] smem_exp = {memr_n | !cpu_sysmem, memw_n | !cpu_sysmem};
  always #4 clock = !clock;
  slot_bus_ctrl #(.SLOT_DIV(2), .REFRESH_AW(8)) dut (.clock, .nrst, .strap_line_a, .rom_select_pin,
    .cfg_addr, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata, .cpu_req, .cpu_type, .cpu_sysmem, .cpu_busy,
    .cpu_done, .cpu_wide, .refresh_req, .refresh_done, .dma_active, .dma_ack, .master_n, .dma_ready,
    .master_granted, .ior_n, .iow_n, .memr_n, .memw_n, .smemr_n, .smemw_n, .cmd_oe, .bale, .aen,
    .refresh_n, .refresh_addr, .refresh_addr_oe, .mem_cs16_n, .io_cs16_n, .iochrdy, .ws0_n,
    .rom_width_select, .slot_drive_strength, .pio_timing_select);
  slot_card card (.clock, .nrst, .ior_n, .iow_n, .memr_n, .memw_n, .bale, .aen, .wide(card_wide),
    .fast(card_fast), .stall(card_stall), .mem_cs16_n, .io_cs16_n, .iochrdy, .ws0_n);
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  // Strobe length in clocks: waits plus one, in slot ticks of two clocks
  function automatic logic [7:0] exp_len(input logic [1:0] t, input logic w, input logic [7:0] c);
    logic [7:0] n;
    n = w ? {7'h00, c[1]} : 8'h04 + {7'h00, c[0]};
    if (t <= 2'h1 && !c[5]) n = n + 8'h01;
    return (n + 8'h01) * 8'h02;
  endfunction : exp_len
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : check
  task automatic complete_run;
    fails += exp_q.size();
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic cfg_access(input logic [7:0] a, input logic [7:0] d, input logic rd);
    @(posedge clock);
    cfg_addr <= a;
    cfg_wdata <= d;
    if (rd) exp_q.push_back(d);
    cfg_rd <= rd;
    cfg_wr <= !rd;
    @(posedge clock);
    cfg_rd <= 1'b0;
    cfg_wr <= 1'b0;
  endtask : cfg_access
  task automatic cpu_cycle(input logic [1:0] t, input logic w, input logic [1:0] m, input logic [7:0] e);
    int k;
    exp_q.push_back(e);
    @(posedge clock);
    card_wide <= w;
    mode <= m;
    cpu_req <= 1'b1;
    cpu_type <= slot_bus_pkg::slot_cycle_t'(t);
    rnd = lfsr(rnd);
    cpu_sysmem <= rnd[0];
    for (k = 0; k < 300 && cpu_busy !== 1'b1; k++) @(posedge clock);
    if (k >= 300) fails++;
    cpu_req <= 1'b0;
    for (k = 0; k < 300 && cpu_done !== 1'b1; k++) @(posedge clock);
    if (k >= 300) fails++;
  endtask : cpu_cycle
  // Results are matched against notes in the order they were made
  always @(posedge clock) begin
    if (rd_q) check(cfg_rdata, exp_q.pop_front(), "register read");
    rd_q <= cfg_rd;
    if (refresh_done === 1'b1) check(refresh_addr, exp_q.pop_front(), "refresh address");
    if (cpu_busy === 1'b1) check({6'h00, smemr_n, smemw_n}, {6'h00, smem_exp}, "system memory strobes");
    if (cpu_busy === 1'b1 && !(ior_n && iow_n && memr_n && memw_n)) begin
      len <= len + 8'h01;
    end else if (len != 8'h00) begin
      v = (mode == 2'h0) ? len : {7'h00, (mode == 2'h1) ? (len < 8'h08) : (len > 8'h08)};
      check(v, exp_q.pop_front(), "strobe length");
      len <= 8'h00;
    end
  end
  initial begin
    #200000;
    fails++;
    complete_run();
  end
  initial begin
    {clock, nrst, cfg_wr, cfg_rd, cpu_req, cpu_sysmem, refresh_req, dma_active, dma_ack} = 9'h000;
    {strap_line_a, rom_select_pin, master_n, card_wide, card_fast, rd_q} = 6'h28;
    {cfg_addr, cfg_wdata, len, card_stall, mode, rnd} = {24'h000000, 6'h00, 8'h25};
    cpu_type = slot_bus_pkg::CYC_IO_RD;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    cfg_access(slot_bus_pkg::INDEX_PORT, 8'h14, 1'b0);
    cfg_access(slot_bus_pkg::DATA_PORT, 8'h00, 1'b1);
    cfg_access(slot_bus_pkg::DATA_PORT, 8'hFF, 1'b0);
    cfg_access(slot_bus_pkg::INDEX_PORT, slot_bus_pkg::CTRL_INDEX, 1'b0);
    cfg_access(slot_bus_pkg::DATA_PORT, 8'h90, 1'b1);
    repeat (4) begin
      rnd = lfsr(rnd);
      cfg_access(slot_bus_pkg::DATA_PORT, rnd, 1'b0);
      cfg_access(slot_bus_pkg::DATA_PORT, (rnd & slot_bus_pkg::CTRL_WRITE_MASK) | slot_bus_pkg::CTRL_READ_ONES, 1'b1);
    end
    foreach (ctab[i]) begin
      cfg_access(slot_bus_pkg::DATA_PORT, ctab[i], 1'b0);
      for (int t = 0; t < 4; t++) begin
        for (int w = 0; w < 2; w++) cpu_cycle(t[1:0], w[0], 2'h0, exp_len(t[1:0], w[0], ctab[i]));
      end
    end
    card_fast <= 1'b1;
    cpu_cycle(2'h2, 1'b0, 2'h1, 8'h01);
    card_fast <= 1'b0;
    card_stall <= 4'h9;
    cpu_cycle(2'h3, 1'b1, 2'h2, 8'h01);
    card_stall <= 4'h6;
    for (int r = 0; r < 2; r++) begin
      exp_q.push_back(r[7:0]);
      refresh_req <= 1'b1;
      for (spin = 0; spin < 300 && refresh_done !== 1'b1; spin++) @(posedge clock);
      if (spin >= 300) fails++;
      refresh_req <= 1'b0;
      repeat (4) @(posedge clock);
    end
    card_stall <= 4'h5;
    dma_active <= 1'b1;
    repeat (20) @(posedge clock);
    dma_ack <= 1'b1;
    repeat (2) @(posedge clock);
    master_n <= 1'b0;
    repeat (20) @(posedge clock);
    {dma_active, dma_ack, master_n} <= 3'h1;
    repeat (10) @(posedge clock);
    complete_run();
  end
endmodule : tb
`default_nettype wire
